// >>> logic/pps_pkg.sv
// Package of constants and types for the power and port pin block
package pps_pkg;
  // Clock rate in Hz
  localparam int unsigned CLK_HZ        = 10000000;
  // Post-enable wait before writes, in microseconds
  localparam int unsigned WAKE_WAIT_US  = 200;
  localparam int unsigned WAKE_WAIT_CYC =
    (WAKE_WAIT_US * (CLK_HZ / 1000000) < 1) ? 1 :
    WAKE_WAIT_US * (CLK_HZ / 1000000);
  // Serial frame layout: one direction bit, address, data
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned FRAME_BITS    = 1 + ADDR_W + DATA_W;
  localparam int unsigned CNT_W         = 5;
  localparam int unsigned WAIT_W        = 12;
  // Default register values after enable
  localparam logic [7:0]  CFG_DEFAULT   = 8'h00;
  // Address of the control register holding the clock output enable
  localparam logic [6:0]  CTRL_ADDR     = 7'h00;
  localparam int unsigned CLKOUT_BIT    = 0;
  // Position of the direction bit in the command field
  localparam int unsigned DIR_POS       = ADDR_W;

  typedef enum logic [1:0] {
    PWR_SHUTDOWN,
    PWR_SETTLE,
    PWR_SLEEP
  } pps_pwr_type;

  typedef struct packed {
    logic [2:0]            sd_sync;
    logic [2:0]            sck_sync;
    logic [1:0]            cs_sync;
    logic [1:0]            sdi_sync;
    logic [1:0]            rx_sync;
    logic [1:0]            rclk_sync;
    pps_pwr_type           pwr;
    logic [WAIT_W-1:0]     wait_cnt;
    logic [CNT_W-1:0]      bit_cnt;
    logic [ADDR_W:0]       cmd;
    logic [DATA_W-1:0]     wdata;
    logic [DATA_W-1:0]     rdata;
    logic [DATA_W-1:0]     ctrl;
    logic                  sdo;
    logic                  sdo_en;
    logic                  data_out;
    logic                  clk_out;
    logic                  shutdown;
    logic                  reject;
  } pps_state_type;
endpackage : pps_pkg

// >>> logic/pps_top.sv
// Power-down, serial port select and receive pin logic
`timescale 1ns/100ps
// How it works
// - Shutdown request high means shutdown; low enables the device.
// - Each falling edge of shutdown request resets configuration to defaults.
// - Request tied low: device leaves the shutdown state it holds after reset and never returns to it.
// - Port select is active low; serial activity ignored while high.
// - One two-way data pin carries writes in and reads out, select low only.
// - Register transfers are timed by the host serial clock.
// - Demodulated received bits appear on the data output.
// - Recovered clock appears on clock output only when enabled.
// - On enable, settle for the wake wait, then enter sleep with defaults; serial port powered throughout.
module pps_top (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Power control pin
  input  wire logic shutdown_request_in,
  // Serial register port
  input  wire logic port_select_n,
  input  wire logic sclk_in,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe,
  // Receiver path
  input  wire logic demod_bit_in,
  input  wire logic rec_clk_in,
  output logic      data_out,
  output logic      clk_out,
  // Status
  output logic      shutdown_out,
  output logic      write_rejected
);
  pps_pkg::pps_state_type s_r;
  pps_pkg::pps_state_type s_nxt;

  logic sck_rise;
  logic sck_fall;
  logic sd_fall;
  logic sel;
  logic [pps_pkg::ADDR_W-1:0] addr;

  // One decode for the control register, shared by write and read paths
  function automatic logic hits_ctrl(
    input logic [pps_pkg::ADDR_W-1:0] a
  );
    return a == pps_pkg::CTRL_ADDR;
  endfunction : hits_ctrl

  always_comb begin
    s_nxt = s_r;
    // Pins from outside pass two flops before use
    s_nxt.sd_sync   = {s_r.sd_sync[1:0], shutdown_request_in};
    s_nxt.sck_sync  = {s_r.sck_sync[1:0], sclk_in};
    s_nxt.cs_sync   = {s_r.cs_sync[0], port_select_n};
    s_nxt.sdi_sync  = {s_r.sdi_sync[0], sdio_in};
    s_nxt.rx_sync   = {s_r.rx_sync[0], demod_bit_in};
    s_nxt.rclk_sync = {s_r.rclk_sync[0], rec_clk_in};
    sck_rise = s_r.sck_sync[1] & ~s_r.sck_sync[2];
    sck_fall = ~s_r.sck_sync[1] & s_r.sck_sync[2];
    sd_fall  = ~s_r.sd_sync[1] & s_r.sd_sync[2];
    sel      = ~s_r.cs_sync[1];
    addr     = s_r.cmd[pps_pkg::ADDR_W-1:0];
    s_nxt.reject = 1'b0;

    unique case (s_r.pwr)
      pps_pkg::PWR_SHUTDOWN: begin
        // A falling edge or a low level on the synced pin leaves shutdown; a pin tied low after
        // reset still goes through the same enable path
        if (sd_fall || !s_r.sd_sync[2]) begin
          s_nxt.pwr      = pps_pkg::PWR_SETTLE;
          s_nxt.wait_cnt = '0;
          s_nxt.ctrl     = pps_pkg::CFG_DEFAULT;
        end
      end
      pps_pkg::PWR_SETTLE: begin
        if (s_r.wait_cnt ==
            pps_pkg::WAIT_W'(pps_pkg::WAKE_WAIT_CYC - 1)) begin
          s_nxt.pwr = pps_pkg::PWR_SLEEP;
        end else begin
          s_nxt.wait_cnt = s_r.wait_cnt + 1'b1;
        end
      end
      pps_pkg::PWR_SLEEP: ;
    endcase
    if (sd_fall) begin
      s_nxt.ctrl     = pps_pkg::CFG_DEFAULT;
      s_nxt.pwr      = pps_pkg::PWR_SETTLE;
      s_nxt.wait_cnt = '0;
    end
    if (s_r.sd_sync[1]) begin
      s_nxt.pwr  = pps_pkg::PWR_SHUTDOWN;
      s_nxt.ctrl = pps_pkg::CFG_DEFAULT;
    end

    // Serial port: no access in shutdown
    if (!sel || s_r.pwr == pps_pkg::PWR_SHUTDOWN) begin
      s_nxt.bit_cnt = '0;
      s_nxt.sdo_en  = 1'b0;
    end else begin
      if (sck_rise &&
          s_r.bit_cnt < pps_pkg::CNT_W'(pps_pkg::FRAME_BITS)) begin
        if (s_r.bit_cnt <= pps_pkg::CNT_W'(pps_pkg::ADDR_W)) begin
          s_nxt.cmd = {s_r.cmd[pps_pkg::ADDR_W-1:0], s_r.sdi_sync[1]};
        end else begin
          s_nxt.wdata = {s_r.wdata[pps_pkg::DATA_W-2:0], s_r.sdi_sync[1]};
        end
        s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
        // Last bit of a write frame commits the data
        if (s_r.bit_cnt == pps_pkg::CNT_W'(pps_pkg::FRAME_BITS - 1) &&
            !s_r.cmd[pps_pkg::DIR_POS]) begin
          if (s_r.pwr != pps_pkg::PWR_SLEEP) begin
            s_nxt.reject = 1'b1;
          end else if (hits_ctrl(addr)) begin
            s_nxt.ctrl = {s_r.wdata[pps_pkg::DATA_W-2:0], s_r.sdi_sync[1]};
          end
        end
      end
      // Read data goes out on falling clock after the command field
      if (sck_fall && s_r.cmd[pps_pkg::DIR_POS] &&
          s_r.bit_cnt >= pps_pkg::CNT_W'(pps_pkg::ADDR_W + 1)) begin
        if (s_r.bit_cnt == pps_pkg::CNT_W'(pps_pkg::ADDR_W + 1)) begin
          // Unmapped addresses read as zero rather than floating
          s_nxt.rdata  = hits_ctrl(addr) ? s_r.ctrl : '0;
          s_nxt.sdo    = hits_ctrl(addr) ?
                         s_r.ctrl[pps_pkg::DATA_W-1] : 1'b0;
          s_nxt.sdo_en = 1'b1;
        end else begin
          s_nxt.rdata = {s_r.rdata[pps_pkg::DATA_W-2:0], 1'b0};
          s_nxt.sdo   = s_r.rdata[pps_pkg::DATA_W-2];
        end
      end
    end

    // Receiver outputs held quiet unless powered
    s_nxt.data_out = (s_r.pwr == pps_pkg::PWR_SHUTDOWN) ?
                     1'b0 : s_r.rx_sync[1];
    s_nxt.clk_out  = (s_r.pwr != pps_pkg::PWR_SHUTDOWN) &&
                     s_r.ctrl[pps_pkg::CLKOUT_BIT] &&
                     s_r.rclk_sync[1];
    s_nxt.shutdown = (s_r.pwr == pps_pkg::PWR_SHUTDOWN);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.pwr      <= pps_pkg::PWR_SHUTDOWN;
      s_r.sd_sync  <= 3'h7;
      s_r.cs_sync  <= 2'h3;
      s_r.ctrl     <= pps_pkg::CFG_DEFAULT;
      s_r.shutdown <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sdio_out       = s_r.sdo;
  assign sdio_oe        = s_r.sdo_en;
  assign data_out       = s_r.data_out;
  assign clk_out        = s_r.clk_out;
  assign shutdown_out   = s_r.shutdown;
  assign write_rejected = s_r.reject;
endmodule : pps_top

// >>> verification/pps_checker.sv
// Checker for power and serial port pin behaviour
`timescale 1ns/100ps
module pps_checker (
  input wire logic clk, rst_n, shutdown_request_in, port_select_n,
  input wire logic sclk_in, sdio_in, sdio_out, sdio_oe, demod_bit_in,
  input wire logic rec_clk_in, data_out, clk_out, shutdown_out,
  input wire logic write_rejected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_sd_on; shutdown_request_in [*4] |=> shutdown_out; endproperty
  a_sd_on: assert property (p_sd_on) else $error("no shutdown");
  property p_quiet; shutdown_out [*2] |-> !data_out && !clk_out; endproperty
  a_quiet: assert property (p_quiet) else $error("pins active");
  property p_gnd; !shutdown_request_in [*8] |=> !shutdown_out; endproperty
  a_gnd: assert property (p_gnd) else $error("stuck in shutdown");
  property p_data;
    !shutdown_out [*4] |-> data_out == $past(demod_bit_in, 3);
  endproperty
  a_data: assert property (p_data) else $error("data lag");
  property p_clk; clk_out |-> $past(rec_clk_in, 3); endproperty
  a_clk: assert property (p_clk) else $error("clock out wrong");
  // Control register default keeps the clock output off after enable
  property p_dflt; $fell(shutdown_out) |-> !clk_out [*8]; endproperty
  a_dflt: assert property (p_dflt) else $error("not default");
  property p_oe; port_select_n [*4] |-> !sdio_oe; endproperty
  a_oe: assert property (p_oe) else $error("drives unselected");
  property p_rej; write_rejected |-> !shutdown_out ##1 !write_rejected;
  endproperty
  a_rej: assert property (p_rej) else $error("bad reject");
  c_rej: cover property (write_rejected);
  c_oe: cover property (sdio_oe);
  c_clk: cover property (clk_out);
endmodule : pps_checker

// >>> verification/pps_host.sv
// Host model: power pin and serial port master
`timescale 1ns/100ps
module pps_host (
  input  wire logic clk,
  input  wire logic sdo,
  output logic      pd,
  output logic      cs_n,
  output logic      sck,
  output logic      sdi
);
  initial {pd, cs_n, sck, sdi} = 4'b1100;
  task automatic power_up(input int wait_cyc);
    #1 pd = 1'b1;
    repeat (10000) @(posedge clk);
    #1 pd = 1'b0;
    repeat (wait_cyc) @(posedge clk);
  endtask : power_up
  // Released data line shows the inverse so stale bits cannot pass
  task automatic frame(input logic [15:0] w, output logic [7:0] rd);
    #1 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = (i < 8 && w[15]) ? ~sdi : w[i];
      repeat (4) @(posedge clk);
      #1 sck = 1'b1;
      repeat (4) @(posedge clk);
      #1 rd = {rd[6:0], sdo};
      sck = 1'b0;
    end
    repeat (4) @(posedge clk);
    #1 cs_n = 1'b1;
    sdi = ~sdi;
    repeat (4) @(posedge clk);
  endtask : frame
endmodule : pps_host

// >>> verification/pps_top_tb_top.sv
// Testbench top for the power and port pin block
`timescale 1ns/100ps
module pps_top_tb_top;
  logic       clk, rst_n, demod, rclk, rej_seen;
  logic       pd, cs_n, sck, sdi, sdo, oe, dout, cko, sd, rej;
  logic [7:0] rd;
  logic [5:0] hist;
  int         errors, tests_run;
  wire logic  sdio = oe ? sdo : sdi;
  pps_top DUT (.clk(clk), .rst_n(rst_n), .shutdown_request_in(pd),
    .port_select_n(cs_n), .sclk_in(sck), .sdio_in(sdio), .sdio_out(sdo),
    .sdio_oe(oe), .demod_bit_in(demod), .rec_clk_in(rclk), .data_out(dout),
    .clk_out(cko), .shutdown_out(sd), .write_rejected(rej));
  pps_host h (.clk(clk), .sdo(sdio), .pd(pd), .cs_n(cs_n), .sck(sck),
    .sdi(sdi));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    hist <= {hist[3:0], demod, rclk};
    if (rej) rej_seen <= 1'b1;
    #1 {demod, rclk} = {demod, rclk} + 2'b01;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic t_boot;
    chk({7'h00, sd}, 8'h01);
    h.power_up(2100);
    chk({7'h00, sd}, 8'h00);
    h.frame(16'h8000, rd);
    chk(rd, 8'h00);
  endtask : t_boot
  task automatic t_pins;
    h.frame(16'h0001, rd);
    h.frame(16'h8000, rd);
    chk(rd, 8'h01);
    repeat (4) begin
      @(posedge clk) #2;
      chk({6'h00, dout, cko}, {6'h00, hist[5:4]});
    end
    h.power_up(2100);
    h.frame(16'h8000, rd);
    chk(rd, 8'h00);
    chk({7'h00, cko}, 8'h00);
  endtask : t_pins
  task automatic t_early;
    h.power_up(100);
    #1 rej_seen = 1'b0;
    h.frame(16'h0001, rd);
    chk({7'h00, rej_seen}, 8'h01);
    repeat (2100) @(posedge clk);
    h.frame(16'h8000, rd);
    chk(rd, 8'h00);
  endtask : t_early
  initial begin
    rst_n = 1'b0;
    {errors, tests_run} = '0;
    {rej_seen, hist, demod, rclk} = '0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_boot();
    t_pins();
    t_early();
    final_report();
  end
  // Runs take about 40000 cycles; allow half again
  initial begin
    #6000000;
    errors++;
    final_report();
  end
endmodule : pps_top_tb_top
bind pps_top pps_checker chk (.clk(clk), .rst_n(rst_n),
  .shutdown_request_in(shutdown_request_in), .port_select_n(port_select_n),
  .sclk_in(sclk_in), .sdio_in(sdio_in), .sdio_out(sdio_out),
  .sdio_oe(sdio_oe), .demod_bit_in(demod_bit_in), .rec_clk_in(rec_clk_in),
  .data_out(data_out), .clk_out(clk_out), .shutdown_out(shutdown_out),
  .write_rejected(write_rejected));
